/* File: cac_attr_checker.sv */
// link checker for the attribute block and its controller
`timescale 1ns/10ps
`default_nettype none
module cac_attr_checker #(
	parameter bit HAS_SECONDARY_PORT = 1'b1
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        cfg_req_in,
	input  wire logic        cfg_we_in,
	input  wire logic [8:0]  cfg_idx_in,
	input  wire logic [31:0] cfg_wdata_in,
	input  wire logic [31:0] cfg_rdata_in,
	input  wire logic        cfg_ack_in
);
	logic [255:0] ce_q;
	logic         impl;
	logic         rd_attr;
	logic         rd_cnt;
	assign impl = (cfg_idx_in >= 9'h080 && cfg_idx_in <= 9'h0BF)
		|| (HAS_SECONDARY_PORT && cfg_idx_in >= 9'h060 && cfg_idx_in <= 9'h06F);
	assign rd_attr = cfg_ack_in && !cfg_we_in && !cfg_idx_in[8];
	assign rd_cnt = cfg_ack_in && !cfg_we_in
		&& (cfg_idx_in == 9'h102 || cfg_idx_in == 9'h104);
	// shadow of the enable bits, fed only by acknowledged writes to real slots
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ce_q <= '0;
		end else if (cfg_ack_in && cfg_we_in && !cfg_idx_in[8] && impl) begin
			ce_q[cfg_idx_in[7:0]] <= cfg_wdata_in[0];
		end
	end
	default clocking dcb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	chk_ack_one_cycle: assert property (cfg_req_in && !cfg_ack_in |=> cfg_ack_in)
		else $error("link answer not one cycle after request");
	chk_ack_single_pulse: assert property (cfg_ack_in |=> !cfg_ack_in && !cfg_req_in)
		else $error("link answer or request lingers");
	chk_ack_has_req: assert property (cfg_ack_in |-> cfg_req_in)
		else $error("link answer without request");
	chk_req_held_stable: assert property (cfg_req_in && !cfg_ack_in |=> $stable(cfg_idx_in)
		&& $stable(cfg_we_in) && $stable(cfg_wdata_in))
		else $error("link request changed before answer");
	chk_attr_value: assert property (rd_attr |-> cfg_rdata_in[0] == ce_q[cfg_idx_in[7:0]])
		else $error("enable bit read back wrong");
	chk_attr_upper_zero: assert property (rd_attr |-> cfg_rdata_in[31:1] == 31'h0)
		else $error("upper attribute bits not zero");
	chk_reserved_zero: assert property (rd_attr && !impl |-> cfg_rdata_in == 32'h0)
		else $error("reserved slot not zero");
	chk_count_upper_zero: assert property (rd_cnt |-> cfg_rdata_in[31:16] == 16'h0)
		else $error("count upper bits not zero");
endmodule : cac_attr_checker
`default_nettype wire

/* File: cac_attr_ctl.sv */
// controller: AHB-Lite command slave that sequences attribute updates and evictions
`timescale 1ns/10ps
`default_nettype none
module cac_attr_ctl (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic [31:0]      hrdata_out,
	output logic             hresp_out,
	cac_link_if.ctl          link
);
	typedef enum logic [6:0] {
		ST_IDLE     = 7'b0000001,
		ST_GLB_WR   = 7'b0000010,
		ST_GLB_POLL = 7'b0000100,
		ST_BASE_WR  = 7'b0001000,
		ST_CNT_WR   = 7'b0010000,
		ST_CNT_POLL = 7'b0100000,
		ST_ATTR     = 7'b1000000
	} cac_ctl_st_t;

	typedef struct packed {
		cac_ctl_st_t st;
		logic        req;
		logic        we;
		logic [8:0]  idx;
		logic [31:0] wdata;
		logic [2:0]  op;
		logic [7:0]  region;
		logic [7:0]  blk;
		logic        done;
		logic        err;
		logic [31:0] attr;
		logic        ph_valid;
		logic        ph_write;
		logic [7:0]  ph_addr;
		logic        rd_rdy;
		logic [31:0] hrdata;
	} cac_ctl_state_t;

	cac_ctl_state_t q;
	cac_ctl_state_t d;
	logic        tx_we;
	logic [8:0]  tx_idx;
	logic [31:0] tx_wdata;
	logic        use_l1d;
	logic        ready;

	assign use_l1d = (q.op == cac_pkg::OP_DIS_L1DBLK);
	assign ready = !(q.ph_valid && !q.ph_write && !q.rd_rdy);

	always_comb begin
		d = q;
		tx_we = 1'b0;
		tx_idx = {1'b0, q.region};
		tx_wdata = 32'h0000_0000;
		unique case (q.st)
			ST_GLB_WR: begin
				tx_we = 1'b1;
				tx_idx = cac_pkg::IDX_GLB_FLUSH;
				tx_wdata = 32'h0000_0001;
			end
			ST_GLB_POLL: tx_idx = cac_pkg::IDX_GLB_FLUSH;
			ST_BASE_WR: begin
				tx_we = 1'b1;
				tx_idx = use_l1d ? cac_pkg::IDX_L1D_BASE : cac_pkg::IDX_L2_BASE;
				tx_wdata = {q.region, q.blk, 16'h0000};
			end
			ST_CNT_WR: begin
				tx_we = 1'b1;
				tx_idx = use_l1d ? cac_pkg::IDX_L1D_CNT : cac_pkg::IDX_L2_CNT;
				tx_wdata = {16'h0000, cac_pkg::BLK_WORDS};
			end
			ST_CNT_POLL: tx_idx = use_l1d ? cac_pkg::IDX_L1D_CNT : cac_pkg::IDX_L2_CNT;
			ST_ATTR: begin
				tx_we = (q.op != cac_pkg::OP_READ);
				tx_wdata = {31'h0000_0000, q.op == cac_pkg::OP_ENABLE};
			end
			default: begin
			end
		endcase

		if (q.st != ST_IDLE) begin
			if (!q.req) begin
				d.req = 1'b1;
				d.we = tx_we;
				d.idx = tx_idx;
				d.wdata = tx_wdata;
			end else if (link.cfg_ack) begin
				d.req = 1'b0;
				unique case (q.st)
					ST_GLB_WR: d.st = ST_GLB_POLL;
					ST_GLB_POLL: begin
						if (!link.cfg_rdata[0]) begin
							d.st = ST_ATTR;
						end
					end
					ST_BASE_WR: d.st = ST_CNT_WR;
					ST_CNT_WR: d.st = ST_CNT_POLL;
					ST_CNT_POLL: begin
						if (link.cfg_rdata[cac_pkg::CNT_W-1:0] == 16'h0000) begin
							if (q.blk == cac_pkg::BLK_LAST) begin
								d.st = ST_ATTR;
							end else begin
								d.blk = q.blk + 8'h01;
								d.st = ST_BASE_WR;
							end
						end
					end
					ST_ATTR: begin
						if (q.op == cac_pkg::OP_READ) begin
							d.attr = link.cfg_rdata;
						end
						d.done = 1'b1;
						d.st = ST_IDLE;
					end
					default: d.st = ST_IDLE;
				endcase
			end
		end

		// data phase: writes complete with no wait, reads take one wait state
		if (q.ph_valid && !q.ph_write && !q.rd_rdy) begin
			d.rd_rdy = 1'b1;
			unique case (q.ph_addr)
				cac_pkg::ADDR_STATUS: begin
					d.hrdata = 32'h0000_0000;
					d.hrdata[cac_pkg::ST_BUSY_BIT] = (q.st != ST_IDLE);
					d.hrdata[cac_pkg::ST_DONE_BIT] = q.done;
					d.hrdata[cac_pkg::ST_ERR_BIT] = q.err;
				end
				cac_pkg::ADDR_RDATA:  d.hrdata = q.attr;
				default:              d.hrdata = 32'h0000_0000;
			endcase
		end
		if (q.ph_valid && q.ph_write && hready_in) begin
			if ((q.ph_addr == cac_pkg::ADDR_CMD) && (q.st == ST_IDLE)) begin
				d.op = hwdata_in[cac_pkg::CMD_OP_LSB +: 3];
				d.region = hwdata_in[cac_pkg::CMD_REG_LSB +: 8];
				d.blk = 8'h00;
				d.done = 1'b0;
				d.err = 1'b0;
				unique case (hwdata_in[cac_pkg::CMD_OP_LSB +: 3])
					cac_pkg::OP_READ, cac_pkg::OP_ENABLE: d.st = ST_ATTR;
					cac_pkg::OP_DIS_GLB:                  d.st = ST_GLB_WR;
					cac_pkg::OP_DIS_L2BLK, cac_pkg::OP_DIS_L1DBLK: d.st = ST_BASE_WR;
					default: begin
						d.err = 1'b1;
						d.done = 1'b1;
					end
				endcase
			end
		end
		if (hready_in) begin
			d.ph_valid = hsel_in && htrans_in[cac_pkg::HTRANS_ACT_BIT];
			d.ph_write = hwrite_in;
			d.ph_addr = haddr_in[7:0];
			d.rd_rdy = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			q <= '{st: ST_IDLE, default: '0};
		end else if (ce_in) begin
			q <= d;
		end
	end

	assign hreadyout_out = ready;
	assign hrdata_out = q.hrdata;
	assign hresp_out = cac_pkg::HRESP_OKAY;
	assign link.cfg_req = q.req;
	assign link.cfg_we = q.we;
	assign link.cfg_idx = q.idx;
	assign link.cfg_wdata = q.wdata;
endmodule : cac_attr_ctl
`default_nettype wire

/* File: cac_attr_dev.sv */
// attribute bank, cacheability lookup and cache-maintenance register front end
//
// Contract
// - one register per aligned 16-Mbyte region
// - one enable bit governs all three caches
// - reset clears every enable bit
// - on-chip SRAM always cacheable
// - writing 1 enables caching immediately
// - software evicts region before clearing enable
// - global flush: poll busy bit to zero
// - level-2 block flush: poll count to zero
// - all-SRAM mode: level-1 data block flush
// - larger regions need several block flushes
// - cleared enable means no allocation anywhere
// - registers 128-191 map primary port space
// - registers 96-111 exist only with secondary port
// - secondary port: four areas of four
// - only bit 0 stored, rest read zero
// - global flush bit reads 1 until done
// - nonzero count write starts block operation
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module cac_attr_dev #(
	parameter bit HAS_SECONDARY_PORT = 1'b1
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	cac_link_if.dev          link,
	input  wire logic        lookup_valid_in,
	input  wire logic [31:0] lookup_addr_in,
	output logic             lookup_done_out,
	output logic             lookup_cacheable_out,
	output logic [1:0]       lookup_port_out,
	output logic [1:0]       lookup_cs_out,
	output logic             glb_flush_start_out,
	input  wire logic        glb_flush_done_in,
	output logic             l2blk_start_out,
	output logic [31:0]      l2blk_base_out,
	output logic [15:0]      l2blk_words_out,
	input  wire logic        l2blk_done_in,
	output logic             l1dblk_start_out,
	output logic [31:0]      l1dblk_base_out,
	output logic [15:0]      l1dblk_words_out,
	input  wire logic        l1dblk_done_in
);
	typedef struct packed {
		logic [255:0] ce;
		logic         glb;
		logic [31:0]  l2_base;
		logic [15:0]  l2_cnt;
		logic [31:0]  l1d_base;
		logic [15:0]  l1d_cnt;
		logic         ack;
		logic [31:0]  rdata;
		logic         glb_start;
		logic         l2_start;
		logic         l1d_start;
		logic         lk_done;
		logic         lk_cache;
		logic [1:0]   lk_port;
		logic [1:0]   lk_cs;
	} cac_dev_state_t;

	cac_dev_state_t q;
	cac_dev_state_t d;

	// indices outside both port windows have no storage at all
	function automatic logic is_impl(input logic [7:0] idx);
		logic pri;
		logic sec;
		pri = (idx >= cac_pkg::PRI_FIRST) && (idx <= cac_pkg::PRI_LAST);
		sec = HAS_SECONDARY_PORT && (idx >= cac_pkg::SEC_FIRST)
			&& (idx <= cac_pkg::SEC_LAST);
		return pri || sec;
	endfunction : is_impl

	function automatic logic in_sram(input logic [31:0] addr);
		return (addr >= cac_pkg::SRAM_LO) && (addr <= cac_pkg::SRAM_HI);
	endfunction : in_sram

	function automatic logic [31:0] read_reg(input cac_dev_state_t s, input logic [8:0] idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (idx < cac_pkg::IDX_GLB_FLUSH) begin
			if (is_impl(idx[7:0])) begin
				v[cac_pkg::CE_BIT] = s.ce[idx[7:0]];
			end
		end else begin
			unique case (idx)
				cac_pkg::IDX_GLB_FLUSH: v[0] = s.glb;
				cac_pkg::IDX_L2_BASE:   v = s.l2_base;
				cac_pkg::IDX_L2_CNT:    v[cac_pkg::CNT_W-1:0] = s.l2_cnt;
				cac_pkg::IDX_L1D_BASE:  v = s.l1d_base;
				cac_pkg::IDX_L1D_CNT:   v[cac_pkg::CNT_W-1:0] = s.l1d_cnt;
				default:                v = 32'h0000_0000;
			endcase
		end
		return v;
	endfunction : read_reg

	logic [7:0]  lk_idx;
	logic [31:0] lk_wd;
	logic [7:0]  wr_idx;

	always_comb begin
		d = q;
		d.ack = 1'b0;
		d.glb_start = 1'b0;
		d.l2_start = 1'b0;
		d.l1d_start = 1'b0;
		d.lk_done = 1'b0;
		lk_idx = lookup_addr_in[cac_pkg::REGION_MSB:cac_pkg::REGION_LSB];
		lk_wd = link.cfg_wdata;
		wr_idx = link.cfg_idx[7:0];

		// completion from the cache engines returns the busy indications to 0
		if (q.glb && glb_flush_done_in) begin
			d.glb = 1'b0;
		end
		if ((q.l2_cnt != 16'h0000) && l2blk_done_in) begin
			d.l2_cnt = 16'h0000;
		end
		if ((q.l1d_cnt != 16'h0000) && l1dblk_done_in) begin
			d.l1d_cnt = 16'h0000;
		end

		// one access per request; ack is a single-cycle pulse
		if (link.cfg_req && !q.ack) begin
			d.ack = 1'b1;
			if (link.cfg_we) begin
				if (link.cfg_idx < cac_pkg::IDX_GLB_FLUSH) begin
					if (is_impl(wr_idx)) begin
						d.ce[wr_idx] = lk_wd[cac_pkg::CE_BIT];
					end
				end else begin
					unique case (link.cfg_idx)
						cac_pkg::IDX_GLB_FLUSH: begin
							if (lk_wd[0] && !q.glb) begin
								d.glb = 1'b1;
								d.glb_start = 1'b1;
							end
						end
						cac_pkg::IDX_L2_BASE: begin
							if (q.l2_cnt == 16'h0000) begin
								d.l2_base = lk_wd;
							end
						end
						cac_pkg::IDX_L2_CNT: begin
							if ((q.l2_cnt == 16'h0000) && (lk_wd[cac_pkg::CNT_W-1:0] != 16'h0000)) begin
								d.l2_cnt = lk_wd[cac_pkg::CNT_W-1:0];
								d.l2_start = 1'b1;
							end
						end
						cac_pkg::IDX_L1D_BASE: begin
							if (q.l1d_cnt == 16'h0000) begin
								d.l1d_base = lk_wd;
							end
						end
						cac_pkg::IDX_L1D_CNT: begin
							if ((q.l1d_cnt == 16'h0000) && (lk_wd[cac_pkg::CNT_W-1:0] != 16'h0000)) begin
								d.l1d_cnt = lk_wd[cac_pkg::CNT_W-1:0];
								d.l1d_start = 1'b1;
							end
						end
						default: begin
						end
					endcase
				end
			end else begin
				d.rdata = read_reg(q, link.cfg_idx);
			end
		end

		// lookup answers one cycle later; the answer reflects writes up to the previous edge
		if (lookup_valid_in) begin
			d.lk_done = 1'b1;
			d.lk_cs = 2'h0;
			if (in_sram(lookup_addr_in)) begin
				d.lk_cache = 1'b1;
				d.lk_port = cac_pkg::PORT_SRAM;
			end else begin
				d.lk_cache = is_impl(lk_idx) && q.ce[lk_idx];
				if ((lk_idx >= cac_pkg::PRI_FIRST) && (lk_idx <= cac_pkg::PRI_LAST)) begin
					d.lk_port = cac_pkg::PORT_PRIMARY;
					d.lk_cs = 2'((lk_idx - cac_pkg::PRI_FIRST) >> cac_pkg::PRI_CS_SHIFT);
				end else if (is_impl(lk_idx)) begin
					d.lk_port = cac_pkg::PORT_SECONDARY;
					d.lk_cs = 2'((lk_idx - cac_pkg::SEC_FIRST) >> cac_pkg::SEC_CS_SHIFT);
				end else begin
					d.lk_port = cac_pkg::PORT_NONE;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			q <= '0;
		end else if (ce_in) begin
			q <= d;
		end
	end

	assign link.cfg_ack = q.ack;
	assign link.cfg_rdata = q.rdata;
	// the same bit gates allocation in level-1 program, level-1 data and level-2
	assign lookup_done_out = q.lk_done;
	assign lookup_cacheable_out = q.lk_cache;
	assign lookup_port_out = q.lk_port;
	assign lookup_cs_out = q.lk_cs;
	assign glb_flush_start_out = q.glb_start;
	assign l2blk_start_out = q.l2_start;
	assign l2blk_base_out = q.l2_base;
	assign l2blk_words_out = q.l2_cnt;
	assign l1dblk_start_out = q.l1d_start;
	assign l1dblk_base_out = q.l1d_base;
	assign l1dblk_words_out = q.l1d_cnt;
endmodule : cac_attr_dev
`default_nettype wire

/* File: cac_link_if.sv */
// configuration link between the attribute block and its controller
`timescale 1ns/10ps
`default_nettype none
interface cac_link_if;
	logic        cfg_req;
	logic        cfg_we;
	logic [8:0]  cfg_idx;
	logic [31:0] cfg_wdata;
	logic [31:0] cfg_rdata;
	logic        cfg_ack;
	modport dev (input cfg_req, input cfg_we, input cfg_idx, input cfg_wdata,
		output cfg_rdata, output cfg_ack);
	modport ctl (output cfg_req, output cfg_we, output cfg_idx, output cfg_wdata,
		input cfg_rdata, input cfg_ack);
endinterface : cac_link_if
`default_nettype wire

/* File: cac_pkg.sv */
// shared constants and types for the cacheability attribute control block
package cac_pkg;
	localparam int unsigned  NUM_REGIONS    = 256;
	localparam int unsigned  IDX_W          = 9;
	localparam int unsigned  REGION_MSB     = 31;
	localparam int unsigned  REGION_LSB     = 24;
	localparam int unsigned  CE_BIT         = 0;
	localparam int unsigned  CNT_W          = 16;
	// attribute bank occupies indices 0..255, engine registers sit above it
	localparam logic [8:0]   IDX_GLB_FLUSH  = 9'h100;
	localparam logic [8:0]   IDX_L2_BASE    = 9'h101;
	localparam logic [8:0]   IDX_L2_CNT     = 9'h102;
	localparam logic [8:0]   IDX_L1D_BASE   = 9'h103;
	localparam logic [8:0]   IDX_L1D_CNT    = 9'h104;
	localparam logic [7:0]   PRI_FIRST      = 8'h80;
	localparam logic [7:0]   PRI_LAST       = 8'hBF;
	localparam logic [7:0]   SEC_FIRST      = 8'h60;
	localparam logic [7:0]   SEC_LAST       = 8'h6F;
	localparam int unsigned  PRI_CS_SHIFT   = 4;
	localparam int unsigned  SEC_CS_SHIFT   = 2;
	localparam logic [1:0]   PORT_NONE      = 2'h0;
	localparam logic [1:0]   PORT_PRIMARY   = 2'h1;
	localparam logic [1:0]   PORT_SECONDARY = 2'h2;
	localparam logic [1:0]   PORT_SRAM      = 2'h3;
	localparam logic [31:0]  SRAM_LO        = 32'h0000_0000;
	localparam logic [31:0]  SRAM_HI        = 32'h000F_FFFF;
	// controller register map (byte offsets on the AHB-Lite slave)
	localparam logic [7:0]   ADDR_CMD       = 8'h00;
	localparam logic [7:0]   ADDR_STATUS    = 8'h04;
	localparam logic [7:0]   ADDR_RDATA     = 8'h08;
	localparam int unsigned  CMD_OP_LSB     = 0;
	localparam int unsigned  CMD_REG_LSB    = 8;
	localparam int unsigned  ST_BUSY_BIT    = 0;
	localparam int unsigned  ST_DONE_BIT    = 1;
	localparam int unsigned  ST_ERR_BIT     = 2;
	localparam int unsigned  HTRANS_ACT_BIT = 1;
	localparam logic         HRESP_OKAY     = 1'b0;
	// eviction walks a region in 64 Kbyte blocks, well under the 16-bit count limit
	localparam logic [15:0]  BLK_WORDS      = 16'h4000;
	localparam logic [7:0]   BLK_LAST       = 8'hFF;
	typedef enum logic [2:0] {
		OP_READ       = 3'h0,
		OP_ENABLE     = 3'h1,
		OP_DIS_GLB    = 3'h2,
		OP_DIS_L2BLK  = 3'h3,
		OP_DIS_L1DBLK = 3'h4
	} cac_op_t;
endpackage : cac_pkg

/* File: cacheability_attribute_control_tb.sv */
// self-checking bench for the attribute block and its controller
`timescale 1ns/10ps
`default_nettype none
module cacheability_attribute_control_tb;
	logic         clk_sys_in = 1'b0;
	logic         rst_in = 1'b1;
	logic [31:0]  haddr = 32'h0;
	logic [1:0]   htrans = 2'h0;
	logic         hwrite = 1'b0;
	logic [31:0]  hwdata = 32'h0;
	logic         hready;
	logic [31:0]  hrdata;
	logic         hresp;
	logic         ce = 1'b1;
	logic         lk_v = 1'b0;
	logic [31:0]  lk_a = 32'h0;
	logic         lk_d, lk_c, g_st, l2_st, l1_st;
	logic [1:0]   lk_p, lk_s;
	logic         g_dn = 1'b0, l2_dn = 1'b0, l1_dn = 1'b0, eng = 1'b0;
	logic [31:0]  l2_b, l1_b, st, rnd;
	logic [15:0]  l2_w, l1_w;
	logic [255:0] ce_m = '0;
	logic [7:0]   cur, r;
	logic [2:0]   k;
	int           mismatches = 0, n_checks = 0, seed = 69, cyc = 0, nst = 0, blk = 0;
	logic [7:0]   ix [0:15] = '{8'h00, 8'h5F, 8'h60, 8'h63, 8'h64, 8'h6F, 8'h70, 8'h7F,
		8'h80, 8'h8F, 8'h90, 8'hBF, 8'hC0, 8'hFF, 8'hA5, 8'h6C};
	cac_link_if link();
	cac_attr_dev cac_attr_dev_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
		.link(link), .lookup_valid_in(lk_v), .lookup_addr_in(lk_a), .lookup_done_out(lk_d),
		.lookup_cacheable_out(lk_c), .lookup_port_out(lk_p), .lookup_cs_out(lk_s),
		.glb_flush_start_out(g_st), .glb_flush_done_in(g_dn), .l2blk_start_out(l2_st),
		.l2blk_base_out(l2_b), .l2blk_words_out(l2_w), .l2blk_done_in(l2_dn),
		.l1dblk_start_out(l1_st), .l1dblk_base_out(l1_b), .l1dblk_words_out(l1_w),
		.l1dblk_done_in(l1_dn));
	cac_attr_ctl cac_attr_ctl_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
		.hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
		.hrdata_out(hrdata), .hresp_out(hresp), .link(link));
	cac_attr_checker cac_attr_checker_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cfg_req_in(link.cfg_req), .cfg_we_in(link.cfg_we),
		.cfg_idx_in(link.cfg_idx), .cfg_wdata_in(link.cfg_wdata),
		.cfg_rdata_in(link.cfg_rdata), .cfg_ack_in(link.cfg_ack));
	initial begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_word
	// one single AHB-Lite word transfer; read data lands in st
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		st = hrdata;
		check_word({31'h0, hresp}, {31'h0, cac_pkg::HRESP_OKAY});
	endtask : bus
	task automatic cmd(input logic [2:0] op, input logic [7:0] rg);
		cur = rg;
		blk = 0;
		nst = 0;
		bus(1'b1, 8'h00, {16'h0, rg, 5'h0, op});
		st = 32'h1;
		while (st[0] !== 1'b0) bus(1'b0, 8'h04, 32'h0);
	endtask : cmd
	function automatic logic impl(input logic [7:0] rg);
		return (rg >= 8'h80 && rg <= 8'hBF) || (rg >= 8'h60 && rg <= 8'h6F);
	endfunction : impl
	task automatic look(input logic [31:0] a);
		logic [1:0] p;
		logic [1:0] s;
		logic       c;
		p = 2'h0;
		s = 2'h0;
		if (a <= cac_pkg::SRAM_HI) begin
			p = cac_pkg::PORT_SRAM;
		end else if (a[31:30] == 2'h2) begin
			p = cac_pkg::PORT_PRIMARY;
			s = a[29:28];
		end else if (a[31:28] == 4'h6) begin
			p = cac_pkg::PORT_SECONDARY;
			s = a[27:26];
		end
		c = (p == cac_pkg::PORT_SRAM) || ce_m[a[31:24]];
		@(posedge clk_sys_in);
		lk_v <= 1'b1;
		lk_a <= a;
		@(posedge clk_sys_in);
		lk_v <= 1'b0;
		@(negedge clk_sys_in);
		check_word({26'h0, lk_d, lk_c, lk_p, (lk_p[1] ^ lk_p[0]) ? lk_s : 2'h0},
			{26'h0, 1'b1, c, p, s});
	endtask : look
	// cache engines: answer each start after a random stall
	always begin
		@(negedge clk_sys_in);
		k = {g_st, l2_st, l1_st};
		if (rst_in === 1'b0 && k !== 3'h0) begin
			eng = 1'b1;
			nst++;
			if (!k[2]) begin
				check_word(k[1] ? l2_b : l1_b, {cur, blk[7:0], 16'h0});
				check_word({16'h0, k[1] ? l2_w : l1_w}, {16'h0, cac_pkg::BLK_WORDS});
			end
			blk++;
			repeat (1 + ($random(seed) & 3)) @(posedge clk_sys_in);
			{g_dn, l2_dn, l1_dn} <= k;
			@(posedge clk_sys_in);
			{g_dn, l2_dn, l1_dn} <= 3'h0;
			eng = 1'b0;
		end
	end
	// an enable may only be cleared once no eviction is outstanding
	always @(negedge clk_sys_in) begin
		if (link.cfg_req === 1'b1 && link.cfg_we === 1'b1 && link.cfg_idx < 9'h100
			&& link.cfg_wdata[0] === 1'b0 && eng === 1'b1) begin
			check_word(32'h1, 32'h0);
		end
		cyc++;
		if (cyc > 50000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		bus(1'b0, 8'h04, 32'h0);
		check_word(st, 32'h0);
		bus(1'b0, 8'h0C, 32'h0);
		check_word(st, 32'h0);
		// a held lookup must not be answered while the clock enable is low
		@(posedge clk_sys_in);
		ce <= 1'b0;
		lk_v <= 1'b1;
		repeat (3) begin
			@(negedge clk_sys_in);
			check_word({31'h0, lk_d}, 32'h0);
		end
		@(posedge clk_sys_in);
		ce <= 1'b1;
		lk_v <= 1'b0;
		for (int i = 0; i < 256; i++) begin
			rnd = $random(seed);
			look({i[7:0], rnd[23:0]});
		end
		look(32'h0000_0000);
		look(32'h000F_FFFF);
		look(32'h0010_0000);
		for (int i = 0; i < 26; i++) begin
			rnd = $random(seed);
			r = (i < 16) ? ix[i] : rnd[31:24];
			cmd(3'h1, r);
			check_word(st, 32'h2);
			ce_m[r] = impl(r);
			look({r, rnd[23:0]});
			cmd(3'h0, r);
			bus(1'b0, 8'h08, 32'h0);
			check_word(st, {31'h0, ce_m[r]});
		end
		cmd(3'h5, 8'h80);
		check_word(st, 32'h6);
		for (int op = 2; op <= 4; op++) begin
			r = (op == 2) ? 8'h80 : (op == 3) ? 8'hBF : 8'h60;
			cmd(op[2:0], r);
			check_word(st, 32'h2);
			check_word(32'(nst), (op == 2) ? 32'h1 : 32'h100);
			ce_m[r] = 1'b0;
			look({r, 24'h12_3456});
		end
		// reset in mid-run, with several regions still enabled
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		ce_m = '0;
		bus(1'b0, 8'h04, 32'h0);
		check_word(st, 32'h0);
		for (int i = 0; i < 16; i++) begin
			rnd = $random(seed);
			look({ix[i], rnd[23:0]});
		end
		cmd(3'h0, 8'h8F);
		bus(1'b0, 8'h08, 32'h0);
		check_word(st, 32'h0);
		finish_test();
	end
endmodule : cacheability_attribute_control_tb
`default_nettype wire
